// ### mii_rx_pkg.sv
// Overview of operation
// - sample data-valid on receive clock as qualifier
// - nibble mode captures four bits each valid period
// - data lines ignored while data-valid low
// - sample receive-error on the receive clock
// - error during data-valid marks frame errored
// - receive-error ignored while data-valid low
// - serial codec mode uses data bit 0 only
// - data-valid frames the same in serial mode
// - carrier sense accepted asynchronous to link clocks
// - collision accepted asynchronous to link clocks
// - collision ignored in full duplex
// - carrier and collision same in serial mode
package mii_rx_pkg;

  // ==========================================================
  // widths and positions
  localparam int          NIB_W       = 4;
  localparam int          SER_BIT     = 0;
  localparam int          CNT_W       = 2;
  localparam int          BITS_W      = 3;
  localparam int          MED_W       = 2;
  localparam int          MED_CRS     = 0;
  localparam int          MED_COL     = 1;
  localparam logic [1:0]  SER_LAST    = 2'h3;
  localparam logic [2:0]  NIB_BITS    = 3'h4;

  // ==========================================================
  // receive framing states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'h1,
    RX_FRAME = 2'h2
  } rx_state_e;

endpackage

// ### sync_if.sv
// ==========================================================
// asynchronous levels into the system clock domain
interface sync_if #(
  parameter int W = 2
);
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;

  modport src  (output async_in, input  sync_out);
  modport sync (input  async_in, output sync_out);
endinterface

// ### sync2.sv
module sync2 import mii_rx_pkg::*; #(
  parameter int W = MED_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // levels to synchronise
  sync_if.sync     port
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s q;
  sync_s d;

  // ==========================================================
  // two stages; first stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = port.async_in;
    d.s2 = q.s1;
    if (sys_rst) begin
      d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  assign port.sync_out = q.s2;

endmodule // sync2

// ### mii_receive_status_inputs.sv
module mii_receive_status_inputs import mii_rx_pkg::*; (
  // system clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // configuration, system domain
  input  wire logic              serial_10m_codec_mode,
  input  wire logic              full_duplex,
  // receive link, receive clock domain
  input  wire logic              rx_clk,
  input  wire logic              rx_dv,
  input  wire logic              rx_er,
  input  wire logic [NIB_W-1:0]  rxd,
  // medium status, asynchronous
  input  wire logic              crs,
  input  wire logic              col,
  // received stream, system domain
  output logic                   nib_valid,
  output logic [NIB_W-1:0]       nib_data,
  output logic                   nib_first,
  output logic                   nib_err,
  output logic                   frame_end,
  output logic                   frame_err,
  output logic [BITS_W-1:0]      end_bits,
  output logic [NIB_W-1:0]       end_data,
  output logic                   rx_busy,
  // medium status, system domain
  output logic                   carrier_sense,
  output logic                   collision
);

  // ==========================================================
  // receive clock domain state
  typedef struct packed {
    // synchronisers from the system domain
    logic                rst_s1;
    logic                rst_s2;
    logic                mode_s1;
    logic                mode_s2;
    // mode latched for the whole frame
    logic                serial;
    // pins, registered once on rx_clk
    logic                dv;
    logic                er;
    logic [NIB_W-1:0]    d;
    // framing
    rx_state_e           st;
    logic                err;
    logic                first;
    // serial assembly
    logic [NIB_W-1:0]    shift;
    logic [CNT_W-1:0]    cnt;
    // item handed to the system domain
    logic                tog;
    logic                it_end;
    logic                it_first;
    logic                it_err;
    logic [NIB_W-1:0]    it_data;
    logic [BITS_W-1:0]   it_bits;
  } rx_s;

  // rx side reset value; applied while the synchronised reset is high
  localparam rx_s RX_RST = '{
    // synchronisers from the system domain
    rst_s1   : 1'h1,
    rst_s2   : 1'h1,
    mode_s1  : 1'h0,
    mode_s2  : 1'h0,
    // mode latched for the whole frame
    serial   : 1'h0,
    // pins, registered once on rx_clk
    dv       : 1'h0,
    er       : 1'h0,
    d        : '0,
    // framing
    st       : RX_IDLE,
    err      : 1'h0,
    first    : 1'h0,
    // serial assembly
    shift    : '0,
    cnt      : '0,
    // item handed to the system domain
    tog      : 1'h0,
    it_end   : 1'h0,
    it_first : 1'h0,
    it_err   : 1'h0,
    it_data  : '0,
    it_bits  : '0
  };

  // ==========================================================
  // system clock domain state
  typedef struct packed {
    // toggle synchroniser
    logic                tog_s1;
    logic                tog_s2;
    logic                tog_s3;
    // stream outputs
    logic                nib_valid;
    logic [NIB_W-1:0]    nib_data;
    logic                nib_first;
    logic                nib_err;
    logic                frame_end;
    logic                frame_err;
    logic [BITS_W-1:0]   end_bits;
    logic [NIB_W-1:0]    end_data;
    // busy and medium status
    logic                busy;
    logic                crs;
    logic                col;
  } sys_s;

  // system side reset value
  localparam sys_s SYS_RST = '{
    // toggle synchroniser
    tog_s1    : '0,
    tog_s2    : '0,
    tog_s3    : '0,
    // stream outputs
    nib_valid : '0,
    nib_data  : '0,
    nib_first : '0,
    nib_err   : '0,
    frame_end : '0,
    frame_err : '0,
    end_bits  : '0,
    end_data  : '0,
    // busy and medium status
    busy      : '0,
    crs       : '0,
    col       : '0
  };

  rx_s    rq;
  rx_s    rn;
  sys_s   sq;
  sys_s   sn;
  logic   emit;
  logic   new_item;

  sync_if #(.W(MED_W)) med_if ();

  // ==========================================================
  // carrier and collision synchroniser
  // crs and col may change at any time; nothing reads them
  // before they have passed two flops
  assign med_if.async_in[MED_CRS] = crs;
  assign med_if.async_in[MED_COL] = col;

  sync2 #(
    .W       (MED_W)
  ) u_med_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .port    (med_if.sync)
  );

  // ==========================================================
  // receive clock domain: framing and assembly
  always_comb begin
    rn         = rq;
    emit       = 1'b0;
    // reset request and mode come from the system domain
    rn.rst_s1  = sys_rst;
    rn.rst_s2  = rq.rst_s1;
    rn.mode_s1 = serial_10m_codec_mode;
    rn.mode_s2 = rq.mode_s1;
    // pins are synchronous to rx_clk and registered once
    rn.dv      = rx_dv;
    rn.er      = rx_er;
    rn.d       = rxd;

    // receive framing
    case (rq.st)
      RX_IDLE: begin
        // start of frame: latch the mode, clear the error flag, set first, clear assembly
        if (rq.dv) begin
          rn.st     = RX_FRAME;
          rn.serial = rq.mode_s2;
          rn.err    = 1'b0;
          rn.first  = 1'b1;
          rn.shift  = '0;
          rn.cnt    = '0;
        end
      end
      RX_FRAME: begin
        // end item: leftover serial bits sit in the top of shift
        if (!rq.dv) begin
          rn.st       = RX_IDLE;
          rn.tog      = ~rq.tog;
          rn.it_end   = 1'b1;
          rn.it_first = 1'b0;
          rn.it_err   = rq.err;
          rn.it_data  = rq.shift;
          rn.it_bits  = rq.serial ? {1'b0, rq.cnt} : '0;
        end
      end
      default: begin
        rn.st = RX_IDLE;
      end
    endcase

    // data and error only count while data-valid is high
    if (rq.dv) begin
      rn.err = rn.err | rq.er;
      if (rn.serial) begin
        // shift right: the first bit lands in bit 0 after four bits
        rn.shift = {rq.d[SER_BIT], rn.shift[NIB_W-1:1]};
        rn.cnt   = rn.cnt + 1'b1;
        emit     = (rn.cnt == '0);
      end else begin
        rn.shift = rq.d;
        emit     = 1'b1;
      end
      // hand a finished nibble over
      if (emit) begin
        rn.tog      = ~rq.tog;
        rn.it_end   = 1'b0;
        rn.it_first = rn.first;
        rn.it_err   = rn.err;
        rn.it_data  = rn.shift;
        rn.it_bits  = NIB_BITS;
        rn.first    = 1'b0;
      end
    end

    // reset last so it overrides everything above; the two flops keep
    // running so the release is seen, which needs rx_clk to run while
    // sys_rst is held
    if (rq.rst_s2) begin
      rn        = RX_RST;
      rn.rst_s1 = sys_rst;
      rn.rst_s2 = rq.rst_s1;
    end
  end

  always_ff @(posedge rx_clk) begin
    rq <= rn;
  end

  // ==========================================================
  // system clock domain: item capture and status
  // items cross by a toggle: the rx side flips tog once per item and
  // holds the item fields until the next flip, a full rx_clk period
  // later; the toggle passes two flops here, so the fields are read
  // only after they have stood for some system clocks; this needs an
  // rx_clk period of more than four system clock periods
  assign new_item = sq.tog_s2 ^ sq.tog_s3;

  always_comb begin
    sn           = sq;
    // two flops on the toggle; the third keeps the old value for the edge
    sn.tog_s1    = rq.tog;
    sn.tog_s2    = sq.tog_s1;
    sn.tog_s3    = sq.tog_s2;
    sn.nib_valid = 1'b0;
    sn.frame_end = 1'b0;

    // item fields are held steady for a whole receive period
    if (new_item) begin
      if (rq.it_end) begin
        sn.frame_end = 1'b1;
        sn.frame_err = rq.it_err;
        sn.end_bits  = rq.it_bits;
        sn.end_data  = rq.it_data;
        sn.busy      = 1'b0;
      end else begin
        sn.nib_valid = 1'b1;
        sn.nib_data  = rq.it_data;
        sn.nib_first = rq.it_first;
        sn.nib_err   = rq.it_err;
        sn.busy      = 1'b1;
      end
    end

    // medium status, collision masked in full duplex
    sn.crs = med_if.sync_out[MED_CRS];
    sn.col = med_if.sync_out[MED_COL] & ~full_duplex;

    // reset last so it wins
    if (sys_rst) begin
      sn = SYS_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    sq <= sn;
  end

  // ==========================================================
  // outputs
  // all outputs come straight from flops
  assign nib_valid     = sq.nib_valid;
  assign nib_data      = sq.nib_data;
  assign nib_first     = sq.nib_first;
  assign nib_err       = sq.nib_err;
  assign frame_end     = sq.frame_end;
  assign frame_err     = sq.frame_err;
  assign end_bits      = sq.end_bits;
  assign end_data      = sq.end_data;
  assign rx_busy       = sq.busy;
  assign carrier_sense = sq.crs;
  assign collision     = sq.col;

endmodule // mii_receive_status_inputs

// ### mii_rx_properties.sv
// ==========================================
// receive and medium status properties
module mii_rx_checker (
  // clock, reset and configuration
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic full_duplex,
  // medium inputs
  input wire logic crs,
  input wire logic col,
  // outputs watched
  input wire logic nib_valid,
  input wire logic nib_first,
  input wire logic nib_err,
  input wire logic frame_end,
  input wire logic frame_err,
  input wire logic rx_busy,
  input wire logic carrier_sense,
  input wire logic collision
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  logic       fr_q;
  logic       er_q;
  // cycles since reset, frame open, error seen in frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      up_q <= 3'h0;
      fr_q <= 1'b0;
      er_q <= 1'b0;
    end else begin
      up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      fr_q <= nib_valid | (fr_q & ~frame_end);
      er_q <= (nib_valid & nib_err) | (er_q & ~frame_end);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_carrier_lag:
    assert property (up_q == 3'h7 |-> carrier_sense == $past(crs, 3)) else $error("carrier lag");
  a_collision_lag:
    assert property ((up_q == 3'h7 && !$past(full_duplex) && !$past(full_duplex, 2))
      |-> collision == $past(col, 3)) else $error("collision lag");
  a_duplex_mask:
    assert property (($past(full_duplex) && $past(full_duplex, 2)) |-> !collision)
      else $error("collision not masked");
  a_nibble_pulse:
    assert property (nib_valid |=> !nib_valid) else $error("nibble pulse long");
  a_busy_data:
    assert property (nib_valid |=> rx_busy) else $error("busy not set");
  a_end_idle:
    assert property (frame_end |-> !rx_busy) else $error("busy at end");
  a_first_nibble:
    assert property (nib_valid && !fr_q |-> nib_first) else $error("first flag missing");
  a_later_nibble:
    assert property (nib_valid && fr_q |-> !nib_first) else $error("first flag extra");
  a_frame_err:
    assert property (frame_end && er_q |-> frame_err) else $error("frame error lost");
  cover property (nib_valid && nib_err);
  cover property (frame_end && !frame_err);
  cover property (collision);
endmodule // mii_rx_checker

bind mii_receive_status_inputs mii_rx_checker u_chk (.sys_clk, .sys_rst, .full_duplex,
  .crs, .col, .nib_valid, .nib_first, .nib_err, .frame_end, .frame_err, .rx_busy,
  .carrier_sense, .collision);

// ### mii_phy_model.sv
// ==========================================
// receive side of the phy
module mii_phy_model import mii_rx_pkg::*; (
  // receive link
  output logic             rx_clk,
  output logic             rx_dv,
  output logic             rx_er,
  output logic [NIB_W-1:0] rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  bit busy = 1'b0;
  bit ser_m = 1'b0;
  initial begin
    {rx_clk, rx_dv, rx_er, rxd} = 7'h05;
    // faster than a real 10Mbps link; the block only needs an rx_clk
    // period of more than four system clocks
    forever #40 rx_clk = ~rx_clk;
  end
  // lines carry changing junk between frames, except rx_er, which is held low after a serial frame
  always @(posedge rx_clk) begin
    if (!busy) begin
      rxd <= ~rxd;
      rx_er <= ~rx_er & ~ser_m;
    end
  end
  task automatic send(input logic [NIB_W-1:0] q[$], input bit ser, input int e,
                      input int xb = 0, input logic [NIB_W-1:0] xv = '0);
    busy = 1'b1;
    ser_m = ser;
    for (int i = 0; i < q.size(); i++) begin
      for (int b = 0; b < (ser ? 4 : 1); b++) begin
        @(posedge rx_clk);
        rx_dv <= 1'b1;
        rx_er <= (i == e);
        rxd <= ser ? {~rxd[3:1], q[i][b]} : q[i];
      end
    end
    // leftover serial bits after the last whole nibble
    for (int b = 0; b < xb; b++) begin
      @(posedge rx_clk);
      rx_dv <= 1'b1;
      rx_er <= 1'b0;
      rxd <= {~rxd[3:1], xv[b]};
    end
    @(posedge rx_clk);
    rx_dv <= 1'b0;
    busy = 1'b0;
  endtask
endmodule // mii_phy_model

// ### tb_top.sv
module tb_top import mii_rx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, serial_10m_codec_mode, full_duplex, crs, col, rx_clk, rx_dv, rx_er;
  logic nib_valid, nib_first, nib_err, frame_end, frame_err, rx_busy, carrier_sense, collision;
  logic [NIB_W-1:0]  rxd, nib_data, end_data;
  logic [BITS_W-1:0] end_bits;
  logic [NIB_W-1:0]  exp_q[$];
  logic [NIB_W-1:0]  xv_at;
  int n_errors = 0, n_tests = 0, cyc = 0, er_at, nib_i, n, xb_at;
  bit done;
  mii_phy_model phy (.rx_clk, .rx_dv, .rx_er, .rxd);
  mii_receive_status_inputs DUT (.sys_clk, .sys_rst, .serial_10m_codec_mode, .full_duplex,
    .rx_clk, .rx_dv, .rx_er, .rxd, .crs, .col, .nib_valid, .nib_data, .nib_first, .nib_err,
    .frame_end, .frame_err, .end_bits, .end_data, .rx_busy, .carrier_sense, .collision);
  function automatic bit exp_err(input int i, input int e);
    return e >= 0 && i >= e;
  endfunction
  task automatic chk(input logic [NIB_W-1:0] got, input logic [NIB_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================
  // stream monitor and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (nib_valid) begin
      chk(nib_data, exp_q.pop_front());
      chk(nib_first, nib_i == 0);
      chk(nib_err, exp_err(nib_i, er_at));
      nib_i++;
    end
    if (frame_end) begin
      chk(frame_err, er_at >= 0);
      chk(end_bits, NIB_W'(xb_at));
      if (xb_at > 0) begin
        chk(end_data >> (NIB_W - xb_at), xv_at & NIB_W'((1 << xb_at) - 1));
      end
      chk(exp_q.size(), 0);
      done = 1'b1;
    end
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic frame(input int len, input bit ser, input int e, input int xb = 0);
    logic [NIB_W-1:0] q[$];
    logic [NIB_W-1:0] xv;
    for (int i = 0; i < len; i++) q.push_back(NIB_W'($urandom));
    xv = NIB_W'($urandom);
    serial_10m_codec_mode <= ser;
    repeat (40) @(posedge sys_clk);
    exp_q = q;
    er_at = e;
    xb_at = xb;
    xv_at = xv;
    nib_i = 0;
    done = 1'b0;
    phy.send(q, ser, e, xb, xv);
    for (int w = 0; w < 100 && !done; w++) @(posedge sys_clk);
    chk(done, 1'b1);
  endtask
  initial begin
    void'($urandom(32'hdb33));
    {sys_rst, serial_10m_codec_mode, full_duplex, crs, col} = 5'h10;
    repeat (40) @(posedge sys_clk);
    sys_rst <= 1'b0;
    frame(1, 1'b0, -1);
    frame(2, 1'b0, 1);
    frame(3, 1'b0, -1);
    frame(1, 1'b1, -1);
    frame(2, 1'b1, -1, 3);
    for (int k = 0; k < 6; k++) begin
      n = 1 + $urandom % 20;
      frame(n, k[0], k[0] ? -1 : int'($urandom % n), k[0] ? int'($urandom % 4) : 0);
    end
    for (int k = 0; k < 8; k++) begin
      crs <= k[0] | k[1];
      col <= k[1];
      full_duplex <= k[2];
      repeat (6) @(posedge sys_clk);
      chk(carrier_sense, k[0] | k[1]);
      chk(collision, k[1] & ~k[2]);
    end
    close_out();
  end
endmodule // tb_top
